/* logic/ifd_map.svh */
// Purpose: Field positions, codes and cycle figures of the decoder
// Assumes: 16-bit program words, first word carries the whole format
// Notes:   Definitions only; included by bare name
`ifndef IFD_MAP_SVH
`define IFD_MAP_SVH
// ------------------------------------------------------------
// First-word field positions
// ------------------------------------------------------------
`define IFD_PMK_LSB      14     // Parallel transfer kind, 2 bits
`define IFD_EXT_LSB      12     // Extension word count, 2 bits
`define IFD_GRP_LSB      10     // Instruction group, 2 bits
`define IFD_OP_LSB       5      // Arithmetic operation, 5 bits
`define IFD_MODE_LSB     3      // Operand addressing mode, 2 bits
// ------------------------------------------------------------
// Field codes
// ------------------------------------------------------------
`define IFD_PMK_NONE     2'h0
`define IFD_PMK_SINGLE   2'h1
`define IFD_PMK_DUAL     2'h2
`define IFD_PMK_RSV      2'h3
`define IFD_GRP_ARITH    2'h0
`define IFD_GRP_LOGIC    2'h1
`define IFD_GRP_MEMORY   2'h2
`define IFD_GRP_FLOW     2'h3
`define IFD_MODE_REG     2'h0
`define IFD_MODE_IMM     2'h1
`define IFD_MODE_MEM     2'h2
`define IFD_MODE_RSV     2'h3
`define IFD_EXT_RSV      2'h3
`define IFD_OP_LAST      5'h1c  // Highest defined operation code
// ------------------------------------------------------------
// Widths, cycle figures and reset values
// ------------------------------------------------------------
`define IFD_ACC_W        6'h24  // Full accumulator, 36 bits
`define IFD_HALF_W       6'h10  // One word, 16 bits
`define IFD_BASE_CYC     3'h1   // Plain one-word instruction
`define IFD_MULTI_CYC    3'h1   // Added for any extension word
`define IFD_MEM_CYC      3'h1   // Added for memory operand
`define IFD_RST_WORD     16'h0000
`endif

/* logic/ifd_pkg.sv */
// Purpose: Types shared by the instruction format decoder
// Assumes: Codes match ifd_map.svh
// Notes:   Types only; numbers live in the map header
package ifd_pkg;
  // ----------------------------------------------------------
  // Arithmetic operations
  // ----------------------------------------------------------
  typedef enum logic [4:0] {
    OP_ABS_VALUE = 5'h00, OP_ADD_WITH_CARRY = 5'h01, OP_ADD = 5'h02,
    OP_ARITH_SHIFT_LEFT_SINGLE = 5'h03, OP_ARITH_MULTIBIT_LEFT = 5'h04,
    OP_ARITH_SHIFT_RIGHT_SINGLE = 5'h05,
    OP_ARITH_SHIFT_RIGHT_ACCUMULATE = 5'h06, OP_ARITH_MULTIBIT_RIGHT = 5'h07,
    OP_CLEAR = 5'h08, OP_COMPARE = 5'h09, OP_LOWER_UPPER_WORD = 5'h0a,
    OP_QUOTIENT_ITERATION = 5'h0b, OP_INTEGER_MULTIPLY = 5'h0c,
    OP_INCREMENT_UPPER = 5'h0d, OP_MULT_ACCUMULATE = 5'h0e,
    OP_ROUNDED_MULT_ACCUMULATE = 5'h0f, OP_MIXED_SIGN_MULT_ACCUMULATE = 5'h10,
    OP_MULTIPLY = 5'h11, OP_ROUNDED_MULTIPLY = 5'h12,
    OP_MIXED_SIGN_MULTIPLY = 5'h13, OP_NEGATE = 5'h14,
    OP_LEADING_BIT_ALIGN = 5'h15, OP_ROUND = 5'h16,
    OP_SUBTRACT_WITH_CARRY = 5'h17, OP_SUBTRACT = 5'h18,
    OP_CONDITIONAL_TRANSFER = 5'h19, OP_TRANSFER = 5'h1a,
    OP_ACCUMULATOR_TEST = 5'h1b, OP_WORD_TEST = 5'h1c
  } ifd_op_t;
  // Sequencer states
  typedef enum logic [1:0] {
    ST_FETCH = 2'b00, ST_EXT = 2'b01, ST_WAIT = 2'b10
  } ifd_state_t;
  // Condition code update scope
  typedef enum logic [1:0] {
    CCR_NONE = 2'b00, CCR_PART = 2'b01, CCR_FULL = 2'b10
  } ifd_ccr_t;
  // ----------------------------------------------------------
  // Decoded instruction carrier
  // ----------------------------------------------------------
  typedef struct packed {
    ifd_op_t    op;         // Arithmetic operation
    logic [1:0] grp;        // Instruction group
    logic [1:0] pm_kind;    // Requested parallel transfer kind
    logic [1:0] mode;       // Operand addressing mode
    logic [1:0] len;        // Length in words, 1 to 3
    logic [2:0] cycles;     // Execution cycles
    logic       illegal;    // Encoding refused
    logic       pm_ok;      // Parallel transfer granted
    logic       core_bus_en; // Core global data bus used
    logic       sec_bus_en;  // Secondary X data bus used
    logic [1:0] agu_upd;    // Address register updates
    logic [5:0] acc_width;  // Operand width in bits
    logic       upper_only; // Only upper accumulator word touched
    logic       round_en;   // Result is rounded
    logic       mixed_sign; // One multiplier operand unsigned
    ifd_ccr_t   ccr;        // Condition code scope
  } ifd_decode_t;
endpackage

/* logic/ifd_decoder.sv */
// Purpose: Instruction length and arithmetic/parallel-move decode
// Assumes: Program memory on the same clock, valid/ready handshake
// Notes:   One decoded instruction per issue pulse
//
// Contract
// (RULE_01) Accept one, two or three words
// (RULE_02) Length and operation from first word
// (RULE_03) Multi-word adds one execution cycle
// (RULE_04) ALU op plus two transfers, one cycle
// (RULE_05) Fetch next word while executing
// (RULE_06) Memory, logical, flow ops: no transfers
// (RULE_07) Arithmetic updates some or all codes; the two transfer ops here update none
// (RULE_08) Register operands use no data bus
// (RULE_09) Transfers use both buses during op
// (RULE_10) Memory operand mode adds cycles
// (RULE_11) Listed operations refuse parallel transfers
// (RULE_12) Single-bit shifts use 36 bits
// (RULE_13) Word test 16, accumulator test 36
// (RULE_14) Increment/decrement touch upper word only
// (RULE_15) Rounded and mixed-sign multiply variants
// (RULE_16) Single move: one transfer, one cycle
// (RULE_17) Dual read: two X reads, one cycle
// (RULE_18) Transfers only with ALU operations
// (RULE_19) Bad pairing illegal, transfer not issued
// (RULE_20) Stall fetch until extension words read
`include "ifd_map.svh"
`timescale 1ns/1ps
`default_nettype none
module ifd_decoder
  import ifd_pkg::*;
#(
  parameter int WORD_W = 16  // Program word width
)(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // Program memory words
  input  wire logic [WORD_W-1:0] program_data_bus_word,
  input  wire logic              program_data_bus_valid,
  output logic                   program_data_bus_ready,
  // Decoded instruction
  output logic                   issue,
  output ifd_decode_t            decode,
  output logic [1:0][WORD_W-1:0] ext_words,
  // Bus strobes with the issue
  output logic                   core_global_data_bus_go,
  output logic                   secondary_x_data_bus_go
);
  // ----------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------
  if (WORD_W != 16) begin : g_bad_width
    $error("ifd_decoder serves 16-bit program words only");
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // ----------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------
  ifd_state_t            state_q;      // Sequencer state
  ifd_decode_t           decode_q;     // Held decode
  ifd_decode_t           decode_d;     // Decode of current word
  logic [1:0][WORD_W-1:0] ext_q;       // Extension words
  logic                  ext_idx_q;    // Next extension slot
  logic [1:0]            ext_left_q;   // Extension words still due
  logic [1:0]            wait_left_q;  // Extra cycles still due
  logic                  issue_q;      // Issue pulse
  logic                  core_go_q;    // Primary bus strobe
  logic                  sec_go_q;     // Secondary bus strobe
  logic [1:0]            pmk;          // Raw fields of first word
  logic [1:0]            ext_raw;
  logic [1:0]            ext_n;        // Extension count, sanitised
  logic [1:0]            grp;
  logic [1:0]            mode;
  logic [4:0]            op_raw;
  logic                  op_ok;        // Defined operation code
  logic                  pm_allow;     // Operation permits transfers
  logic                  is_arith;
  logic                  mem_op;       // Arithmetic with memory operand
  logic [1:0]            wait_n;       // Extra cycles for this word
  logic                  accept;       // Word taken this cycle

  assign accept                  = program_data_bus_valid & program_data_bus_ready;
  assign issue                   = issue_q;
  assign decode                  = decode_q;
  assign ext_words               = ext_q;
  assign core_global_data_bus_go = core_go_q;
  assign secondary_x_data_bus_go = sec_go_q;

  // ----------------------------------------------------------
  // First-word field split
  // ----------------------------------------------------------
  // Everything below looks at this word only
  assign pmk      = program_data_bus_word[`IFD_PMK_LSB +: 2];  // RULE_02
  assign ext_raw  = program_data_bus_word[`IFD_EXT_LSB +: 2];
  assign grp      = program_data_bus_word[`IFD_GRP_LSB +: 2];
  assign mode     = program_data_bus_word[`IFD_MODE_LSB +: 2];
  assign op_raw   = program_data_bus_word[`IFD_OP_LSB +: 5];
  // Reserved count fetched as one word so the stream stays aligned
  assign ext_n    = (ext_raw == `IFD_EXT_RSV) ? 2'h0 : ext_raw;  // RULE_01
  assign is_arith = (grp == `IFD_GRP_ARITH);
  assign op_ok    = !is_arith || (op_raw <= `IFD_OP_LAST);
  assign mem_op   = is_arith && (mode == `IFD_MODE_MEM);
  assign wait_n   = {1'b0, ext_n != 2'h0} + {1'b0, mem_op};  // RULE_03 RULE_10

  // ----------------------------------------------------------
  // Operations that refuse parallel transfers
  // ----------------------------------------------------------
  always_comb
  begin
    unique case (ifd_op_t'(op_raw))
      OP_ADD_WITH_CARRY, OP_SUBTRACT_WITH_CARRY, OP_ARITH_MULTIBIT_LEFT,
      OP_ARITH_MULTIBIT_RIGHT, OP_ARITH_SHIFT_RIGHT_ACCUMULATE,
      OP_QUOTIENT_ITERATION, OP_INTEGER_MULTIPLY,
      OP_MIXED_SIGN_MULT_ACCUMULATE, OP_MIXED_SIGN_MULTIPLY,
      OP_LEADING_BIT_ALIGN, OP_CONDITIONAL_TRANSFER, OP_WORD_TEST:
        pm_allow = 1'b0;  // RULE_11
      default:
        pm_allow = op_ok;  // Undefined codes never permit
    endcase
  end

  // ----------------------------------------------------------
  // Combinational decode of the first word
  // ----------------------------------------------------------
  always_comb
  begin
    decode_d         = '0;
    decode_d.op      = ifd_op_t'(op_raw);
    decode_d.grp     = grp;
    decode_d.pm_kind = pmk;
    decode_d.mode    = mode;
    decode_d.len     = ext_n + 2'h1;  // RULE_01
    decode_d.cycles  = `IFD_BASE_CYC + {1'b0, wait_n};  // RULE_03 RULE_10
    // Transfers only beside a register-direct ALU operation
    decode_d.pm_ok   = (pmk == `IFD_PMK_SINGLE || pmk == `IFD_PMK_DUAL) &&
                       is_arith && pm_allow && (mode == `IFD_MODE_REG);  // RULE_06 RULE_18
    // Any refused pairing or reserved field marks the word illegal
    decode_d.illegal = ((pmk != `IFD_PMK_NONE) && !decode_d.pm_ok) ||
                       (ext_raw == `IFD_EXT_RSV) || !op_ok ||
                       (mode == `IFD_MODE_RSV);  // RULE_19
    // Register operands leave both buses to the transfers
    decode_d.core_bus_en = decode_d.pm_ok || (mem_op && !decode_d.illegal);  // RULE_08 RULE_09
    decode_d.sec_bus_en  = decode_d.pm_ok && (pmk == `IFD_PMK_DUAL);  // RULE_09 RULE_17
    // One address update per transfer
    decode_d.agu_upd = !decode_d.pm_ok ? 2'h0 :
                       (pmk == `IFD_PMK_DUAL) ? 2'h2 : 2'h1;  // RULE_04 RULE_16
    if (is_arith && op_ok)
    begin
      decode_d.acc_width = `IFD_ACC_W;  // RULE_12 RULE_13
      decode_d.ccr       = CCR_FULL;  // RULE_07
      unique case (ifd_op_t'(op_raw))
        OP_WORD_TEST:
        begin
          decode_d.acc_width = `IFD_HALF_W;  // RULE_13
          decode_d.ccr       = CCR_PART;  // RULE_07
        end
        OP_LOWER_UPPER_WORD, OP_INCREMENT_UPPER:
        begin
          decode_d.acc_width  = `IFD_HALF_W;  // RULE_14
          decode_d.upper_only = 1'b1;  // RULE_14
          decode_d.ccr        = CCR_PART;  // RULE_07
        end
        OP_ROUNDED_MULT_ACCUMULATE, OP_ROUNDED_MULTIPLY, OP_ROUND:
          decode_d.round_en = 1'b1;  // RULE_15
        OP_MIXED_SIGN_MULT_ACCUMULATE, OP_MIXED_SIGN_MULTIPLY:
          decode_d.mixed_sign = 1'b1;  // RULE_15
        OP_TRANSFER, OP_CONDITIONAL_TRANSFER:
          decode_d.ccr = CCR_NONE;  // RULE_07
        default:
          decode_d.ccr = CCR_FULL;
      endcase
    end
    else if (grp == `IFD_GRP_LOGIC)
    begin
      decode_d.ccr = CCR_FULL;  // Logical ops still set codes
    end
  end

  // ----------------------------------------------------------
  // Fetch handshake
  // ----------------------------------------------------------
  // Ready while decoding a new word, so fetch overlaps execution;
  // low in the wait state so the next decode stalls
  assign program_data_bus_ready = (state_q != ST_WAIT);  // RULE_05 RULE_20

  // ----------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q     <= ST_FETCH;
      ext_left_q  <= 2'h0;
      wait_left_q <= 2'h0;
      ext_idx_q   <= 1'b0;
      issue_q     <= 1'b0;
    end
    else
    begin
      issue_q <= 1'b0;
      unique case (state_q)
        ST_FETCH:
          if (accept)
          begin
            ext_idx_q   <= 1'b0;
            ext_left_q  <= ext_n;
            wait_left_q <= wait_n;
            if (ext_n != 2'h0)
              state_q <= ST_EXT;  // RULE_01 RULE_20
            else if (wait_n != 2'h0)
              state_q <= ST_WAIT;  // RULE_10
            else
              issue_q <= 1'b1;  // RULE_04 RULE_16 RULE_17
          end
        ST_EXT:
          if (accept)
          begin
            ext_idx_q  <= 1'b1;
            ext_left_q <= ext_left_q - 2'h1;
            if (ext_left_q == 2'h1)
              state_q <= ST_WAIT;  // RULE_03
          end
        ST_WAIT:
        begin
          wait_left_q <= wait_left_q - 2'h1;
          if (wait_left_q == 2'h1)
          begin
            state_q <= ST_FETCH;
            issue_q <= 1'b1;
          end
        end
        default:
          state_q <= ST_FETCH;  // Unused code recovers
      endcase
    end
  end

  // ----------------------------------------------------------
  // Decode and extension word storage
  // ----------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      decode_q <= '0;
      ext_q    <= {`IFD_RST_WORD, `IFD_RST_WORD};
    end
    else if (accept && state_q == ST_FETCH)
      decode_q <= decode_d;  // RULE_02
    else if (accept && state_q == ST_EXT)
      ext_q[ext_idx_q] <= program_data_bus_word;  // RULE_01
  end

  // ----------------------------------------------------------
  // Bus strobes, raised with the issue when a transfer is granted or a memory operand is read
  // ----------------------------------------------------------
  // Refused pairings carry no enables; a reserved extension count still moves a granted transfer
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      core_go_q <= 1'b0;
      sec_go_q  <= 1'b0;
    end
    else
    begin
      core_go_q <= (state_q == ST_FETCH && accept && ext_n == 2'h0 && wait_n == 2'h0)
                   ? decode_d.core_bus_en
                   : (state_q == ST_WAIT && wait_left_q == 2'h1) && decode_q.core_bus_en;  // RULE_09
      sec_go_q  <= (state_q == ST_FETCH && accept && ext_n == 2'h0 && wait_n == 2'h0)
                   ? decode_d.sec_bus_en
                   : (state_q == ST_WAIT && wait_left_q == 2'h1) && decode_q.sec_bus_en;  // RULE_09
    end
  end

  // ----------------------------------------------------------
  // Checks
  // ----------------------------------------------------------
  chk_len_first_word: assert property (  // RULE_02
    (state_q == ST_FETCH && accept) |=> (decode_q.len == $past(ext_n) + 2'h1))
    else $error("length not taken from first word");
  chk_multi_extra_cycle: assert property (  // RULE_03
    (state_q == ST_EXT && accept && ext_left_q == 2'h1 && !decode_q.mode[1])
    |=> (state_q == ST_WAIT && !issue_q) ##1 issue_q)
    else $error("multi-word instruction lacks its extra cycle");
  chk_mem_extra_cycle: assert property (  // RULE_10
    (state_q == ST_FETCH && accept && mem_op && ext_n == 2'h0)
    |=> !issue_q ##1 (issue_q && state_q == ST_FETCH))
    else $error("memory operand cycle missing");
  chk_fetch_overlap: assert property (  // RULE_05
    issue_q && $past(state_q) == ST_FETCH |-> program_data_bus_ready)
    else $error("fetch not overlapped with execution");
  chk_wait_stall: assert property (  // RULE_20
    state_q == ST_WAIT |-> !program_data_bus_ready)
    else $error("fetch not stalled for extra cycle");
  chk_group_no_move: assert property (  // RULE_06
    (decode_q.grp != `IFD_GRP_ARITH) |-> !decode_q.pm_ok && !decode_q.sec_bus_en)
    else $error("transfer granted outside arithmetic group");
  chk_listed_refused: assert property (  // RULE_11
    (state_q == ST_FETCH && accept && !pm_allow) |=> !decode_q.pm_ok)
    else $error("listed operation granted a transfer");
  chk_dual_strobes: assert property (  // RULE_04
    issue_q && decode_q.pm_kind == `IFD_PMK_DUAL && decode_q.pm_ok
    |-> core_global_data_bus_go && secondary_x_data_bus_go && decode_q.agu_upd == 2'h2)
    else $error("dual read did not drive both buses");
  chk_illegal_quiet: assert property (  // RULE_19
    issue_q && decode_q.illegal |-> !secondary_x_data_bus_go && decode_q.agu_upd == 2'h0)
    else $error("illegal encoding issued a transfer");
  chk_reg_no_bus: assert property (  // RULE_08
    issue_q && decode_q.mode == `IFD_MODE_REG && !decode_q.pm_ok
    |-> !core_global_data_bus_go && !secondary_x_data_bus_go)
    else $error("register operation used a data bus");
  chk_width_test: assert property (  // RULE_13
    decode_q.grp == `IFD_GRP_ARITH && decode_q.op == OP_WORD_TEST
    |-> decode_q.acc_width == `IFD_HALF_W)
    else $error("word test width wrong");
endmodule
`default_nettype wire

/* bench/ifd_prog_mem.sv */
// Purpose: Program memory model feeding instruction words
// Assumes: Words are queued by the bench through push
// Notes:   Optional one-cycle gap after each word taken
`timescale 1ns/1ps
`default_nettype none
module ifd_prog_mem (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Word handshake
  input  wire logic        ready,
  input  wire logic        slow,
  output var  logic [15:0] word,
  output var  logic        valid
);
  logic [15:0] mem [0:63]; // Queued words
  int          cnt = 0;    // Words queued so far
  int          rd;         // Word now offered
  int          nx;         // Read index after this edge
  logic        gap;        // Slow mode pause after a take

  // Queue one word; called away from the rising edge
  task automatic push(input logic [15:0] w);
    mem[cnt] = w;
    cnt++;
  endtask

  // Offer words in order; an idle bus shows the inverted last value
  // so a decoder that samples without valid sees garbage, not a copy
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd    <= 0;
      valid <= 1'b0;
      word  <= 16'h0000;
    end
    else
    begin
      nx = rd + ((valid && ready) ? 1 : 0);
      gap = slow && valid && ready;
      rd <= nx;
      valid <= (nx < cnt) && !gap;
      word <= ((nx < cnt) && !gap) ? mem[nx] : ~word;
    end
  end
endmodule
`default_nettype wire

/* bench/tb_ifd_decoder.sv */
// Purpose: Self-checking bench for the instruction format decoder
// Assumes: Program memory model on the far side of the word bus
// Notes:   Each scenario pushes words, waits for issue and judges
`include "ifd_map.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_ifd_decoder
  import ifd_pkg::*;
;
  // ----------------------------------------------------------
  // Signals
  // ----------------------------------------------------------
  logic             clk = 1'b0;   // 50 MHz core clock
  logic             rst_n = 1'b0; // Async reset, low active
  logic             slow = 1'b0;  // Partner pauses between words
  logic [15:0]      pw;           // Word from program memory
  logic             pv;           // Word valid
  logic             prdy;         // Decoder ready
  logic             issue;        // Decoded pulse
  ifd_decode_t      decode;       // Decoded fields
  logic [1:0][15:0] ext_words;    // Extension words
  logic             cg_go;        // Core global data bus strobe
  logic             xd_go;        // Secondary X data bus strobe
  ifd_decode_t      cap;          // Fields captured at issue
  logic [1:0][15:0] ew;           // Extension words captured
  logic             cg_s;         // Strobes captured at issue
  logic             xd_s;
  int               lat;          // Negedges from push to issue
  int               miscompares = 0;
  int               n_compared = 0;

  always #10 clk = ~clk;

  ifd_prog_mem u_mem (.clk(clk), .rst_n(rst_n), .ready(prdy), .slow(slow),
    .word(pw), .valid(pv));
  ifd_decoder u_dut (.clk(clk), .rst_n(rst_n), .program_data_bus_word(pw),
    .program_data_bus_valid(pv), .program_data_bus_ready(prdy), .issue(issue),
    .decode(decode), .ext_words(ext_words), .core_global_data_bus_go(cg_go),
    .secondary_x_data_bus_go(xd_go));

  // ----------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------
  // First word from its fields
  function automatic logic [15:0] enc(input logic [1:0] k, input logic [1:0] x,
    input logic [1:0] g, input ifd_op_t op, input logic [1:0] m);
    return (16'(k) << `IFD_PMK_LSB) | (16'(x) << `IFD_EXT_LSB)
      | (16'(g) << `IFD_GRP_LSB) | (16'(op) << `IFD_OP_LSB) | (16'(m) << `IFD_MODE_LSB);
  endfunction

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("FAIL %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("compared %0d, miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Bounded wait for issue, then capture; a hang ends the run
  task automatic wait_iss();
    lat = 0;
    while (issue !== 1'b1 && lat < 30)
    begin
      @(negedge clk);
      lat++;
    end
    if (lat == 30)
    begin
      miscompares++;
      conclude();
    end
    cap = decode;
    ew = ext_words;
    cg_s = cg_go;
    xd_s = xd_go;
  endtask

  task automatic one(input logic [15:0] w);
    @(negedge clk);
    u_mem.push(w);
    wait_iss();
  endtask

  // ----------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------
  // Single move with add, then a negate right behind it
  task automatic s_single();
    @(negedge clk);
    u_mem.push(enc(2'h1, 2'h0, 2'h0, OP_ADD, 2'h0));
    u_mem.push(enc(2'h1, 2'h0, 2'h0, OP_NEGATE, 2'h0));
    wait_iss();
    chk("one word latency", 32'(lat), 2);
    chk("single pm_ok", 32'(cap.pm_ok), 1);
    chk("single len", 32'(cap.len), 1);
    chk("single cycles", 32'(cap.cycles), 1);
    chk("single agu", 32'(cap.agu_upd), 1);
    chk("single buses", 32'({cg_s, xd_s}), 2);
    @(negedge clk);
    chk("next issue", 32'(issue), 1);
    chk("next op", 32'(decode.op), 32'(OP_NEGATE));
  endtask

  // Dual read with rounded multiply-accumulate
  task automatic s_dual();
    one(enc(2'h2, 2'h0, 2'h0, OP_ROUNDED_MULT_ACCUMULATE, 2'h0));
    chk("dual pm_ok", 32'(cap.pm_ok), 1);
    chk("dual agu", 32'(cap.agu_upd), 2);
    chk("dual buses", 32'({cg_s, xd_s}), 3);
    chk("dual round", 32'(cap.round_en), 1);
    chk("dual cycles", 32'(cap.cycles), 1);
  endtask

  // Every operation that refuses a transfer, asked for one
  task automatic s_refuse();
    ifd_op_t ops [12] = '{OP_ADD_WITH_CARRY, OP_SUBTRACT_WITH_CARRY,
      OP_ARITH_MULTIBIT_LEFT, OP_ARITH_MULTIBIT_RIGHT, OP_ARITH_SHIFT_RIGHT_ACCUMULATE,
      OP_QUOTIENT_ITERATION, OP_INTEGER_MULTIPLY, OP_MIXED_SIGN_MULT_ACCUMULATE,
      OP_MIXED_SIGN_MULTIPLY, OP_LEADING_BIT_ALIGN, OP_CONDITIONAL_TRANSFER, OP_WORD_TEST};
    foreach (ops[i])
    begin
      one(enc(2'h1, 2'h0, 2'h0, ops[i], 2'h0));
      chk("refused illegal", 32'(cap.illegal), 1);
      chk("refused pm_ok", 32'(cap.pm_ok), 0);
      chk("refused buses", 32'({cg_s, xd_s, cap.agu_upd}), 0);
      chk("mixed sign", 32'(cap.mixed_sign), 32'(i == 7 || i == 8));
    end
  endtask

  // Logical, memory and flow groups never carry a transfer
  task automatic s_groups();
    for (int g = 1; g < 4; g++)
    begin
      one(enc(2'h2, 2'h0, 2'(g), OP_ADD, 2'h0));
      chk("group illegal", 32'(cap.illegal), 1);
      chk("group buses", 32'({cg_s, xd_s, cap.pm_ok}), 0);
    end
  endtask

  // Operand widths and condition code scope of register ops
  task automatic s_width();
    ifd_op_t ops [6] = '{OP_ARITH_SHIFT_LEFT_SINGLE, OP_ARITH_SHIFT_RIGHT_SINGLE,
      OP_ACCUMULATOR_TEST, OP_WORD_TEST, OP_INCREMENT_UPPER, OP_LOWER_UPPER_WORD};
    foreach (ops[i])
    begin
      one(enc(2'h0, 2'h0, 2'h0, ops[i], 2'h0));
      chk("acc width", 32'(cap.acc_width), (i < 3) ? 36 : 16);
      chk("upper only", 32'(cap.upper_only), 32'(i > 3));
      chk("ccr scope", 32'(cap.ccr), 32'((i > 2) ? CCR_PART : CCR_FULL));
      chk("reg no bus", 32'({cg_s, xd_s}), 0);
    end
  endtask

  // Extension words, slow memory and memory operands
  task automatic s_multi();
    @(negedge clk);
    u_mem.push(enc(2'h0, 2'h1, 2'h0, OP_ADD, 2'h1));
    u_mem.push(16'h1234);
    wait_iss();
    chk("two word latency", 32'(lat), 4);
    chk("two word len", 32'(cap.len), 2);
    chk("two word cycles", 32'(cap.cycles), 2);
    chk("ext word", 32'(ew[0]), 32'h0000_1234);
    @(posedge clk) slow <= 1'b1;
    @(negedge clk);
    u_mem.push(enc(2'h0, 2'h2, 2'h0, OP_SUBTRACT, 2'h2));
    u_mem.push(16'ha5c3);
    u_mem.push(16'h5a3c);
    wait_iss();
    chk("three word len", 32'(cap.len), 3);
    chk("three word cycles", 32'(cap.cycles), 3);
    chk("ext words", 32'(ew), 32'h5a3c_a5c3);
    @(posedge clk) slow <= 1'b0;
    one(enc(2'h0, 2'h0, 2'h0, OP_ADD, 2'h2));
    chk("mem latency", 32'(lat), 3);
    chk("mem cycles", 32'(cap.cycles), 2);
  endtask

  // ----------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------
  initial
  begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    s_single();
    s_dual();
    s_refuse();
    s_groups();
    s_width();
    s_multi();
    conclude();
  end
endmodule
`default_nettype wire
